// *** design/cps_pkg.sv ***
// Constants shared by the control pin sequencer design files
`default_nettype none
package cps_pkg;
   // Clock rate in MHz (period 4 ns)
   localparam int CLK_MHZ = 250;
   // Counter width for all sequence timers
   localparam int TMR_W = 26;
   // Control bus usable after reset, in microseconds
   localparam int T_CTRL_READY_US = 3000;
   localparam int CTRL_READY_CYCLES = T_CTRL_READY_US * CLK_MHZ;
   // Least time from reset release to full run, in microseconds
   localparam int T_RUN_MIN_US = 10000;
   localparam int RUN_MIN_CYCLES = T_RUN_MIN_US * CLK_MHZ;
   // Start-up after power-down release, in microseconds
   localparam int T_PDN_START_US = 120000;
   localparam int PDN_START_CYCLES = T_PDN_START_US * CLK_MHZ;
   // One recovery unit of one millisecond
   localparam int T_REC_UNIT_US = 1000;
   localparam int REC_UNIT_CYCLES = T_REC_UNIT_US * CLK_MHZ;
   // Recovery interval bounds in milliseconds
   localparam logic [3:0] REC_MS_MIN = 4'h1;
   localparam logic [3:0] REC_MS_MAX = 4'ha;
   // Volume slew base step interval, in nanoseconds
   localparam int T_SLEW_BASE_NS = 1024;
   localparam int SLEW_BASE_CYCLES = T_SLEW_BASE_NS * CLK_MHZ / 1000;
   // Volume width and reset value (silent)
   localparam int VOL_W = 8;
   localparam logic [7:0] VOL_RESET = 8'h00;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_BOOT, ST_PDN_HOLD, ST_PDN_START, ST_RUN, ST_ERR_HOLD, ST_ERR_REC
   } cps_state_type;
endpackage : cps_pkg
`default_nettype wire

// *** design/cps_timer.sv ***
// Saturating elapsed-time counter with synchronous clear
`default_nettype none
module cps_timer #(
   parameter int WIDTH = 26
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Restart from zero
   input wire logic clear,
   // Elapsed cycles since the last clear
   output logic [WIDTH-1:0] count_reg
);
   // Saturate so a long idle never wraps into a false expiry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (ce) begin
         if (clear) begin
            count_reg <= '0;
         end else if (count_reg != {WIDTH{1'b1}}) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule : cps_timer
`default_nettype wire

// *** design/cps_sequencer.sv ***
// Control pin sequencer: reset, power-down, fault recovery, mute ramp
`default_nettype none
module cps_sequencer
   import cps_pkg::*;
#(
   parameter int CTRL_READY = cps_pkg::CTRL_READY_CYCLES,
   parameter int RUN_MIN = cps_pkg::RUN_MIN_CYCLES,
   parameter int PDN_START = cps_pkg::PDN_START_CYCLES,
   parameter int REC_UNIT = cps_pkg::REC_UNIT_CYCLES
) (
   // Clock, reset pin and clock enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control pins from the host
   input wire logic power_down_pin_n,
   input wire logic backend_fault_input_n,
   input wire logic mute_n,
   // Configuration from the control interface
   input wire logic rate_detected,
   input wire logic master_volume_write,
   input wire logic [cps_pkg::VOL_W-1:0] master_volume,
   input wire logic [1:0] volume_slew_rate,
   input wire logic [3:0] recovery_ms,
   // Status outputs
   output logic mod_state_reg,
   output logic control_ready_reg,
   output logic audio_enable_reg,
   output logic [cps_pkg::VOL_W-1:0] volume_reg
);
   import cps_pkg::*;

   // Clamp the recovery setting into its legal 1..10 ms span
   function automatic logic [3:0] clamp_ms(input logic [3:0] v);
      if (v < REC_MS_MIN) begin
         return REC_MS_MIN;
      end else if (v > REC_MS_MAX) begin
         return REC_MS_MAX;
      end
      return v;
   endfunction : clamp_ms

   cps_state_type state_reg; // Sequencer state
   cps_state_type state_next; // Next sequencer state
   logic [TMR_W-1:0] elapsed; // Time in current state
   logic tmr_clear; // Restart state timer on each change
   logic [TMR_W-1:0] rec_limit; // Recovery interval in cycles
   logic vol_cmd_seen_reg; // Master volume command since start
   logic [TMR_W-1:0] slew_count; // Time since last volume step
   logic slew_tick; // Volume step due
   logic [VOL_W-1:0] vol_target; // Where the ramp heads
   logic [TMR_W-1:0] slew_limit; // Step interval in cycles

   // Interval counter for the sequence
   cps_timer #(.WIDTH(TMR_W)) u_seq_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clear(tmr_clear),
      .count_reg(elapsed)
   );

   // Interval counter for the volume slew
   cps_timer #(.WIDTH(TMR_W)) u_slew_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clear(slew_tick),
      .count_reg(slew_count)
   );

   // Recovery length; product stays below the timer range
   assign rec_limit = TMR_W'(int'(clamp_ms(recovery_ms)) * REC_UNIT);

   // Next-state decode; power-down outranks a back-end fault
   always_comb begin
      state_next = state_reg;
      if (!power_down_pin_n) begin
         state_next = ST_PDN_HOLD;
      end else begin
         unique case (state_reg)
            ST_BOOT: begin
               // Full run never before the least start-up time
               if (elapsed >= TMR_W'(RUN_MIN - 1)) state_next = ST_RUN;
            end
            ST_PDN_HOLD: begin
               // Release; host already gave the master clocks
               state_next = ST_PDN_START;
            end
            ST_PDN_START: begin
               if (elapsed >= TMR_W'(PDN_START - 1)) state_next = ST_RUN;
            end
            ST_RUN: begin
               if (!backend_fault_input_n) state_next = ST_ERR_HOLD;
            end
            ST_ERR_HOLD: begin
               if (backend_fault_input_n) state_next = ST_ERR_REC;
            end
            ST_ERR_REC: begin
               // A fresh fault restarts the recovery
               if (!backend_fault_input_n) begin
                  state_next = ST_ERR_HOLD;
               end else if (elapsed >= rec_limit - 1'b1) begin
                  state_next = ST_RUN;
               end
            end
         endcase
      end
   end

   assign tmr_clear = (state_next != state_reg);

   // State register; reset pin restarts the boot sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_BOOT;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // Modulation valid only in run; reset clears it at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_state_reg <= 1'b0;
      end else if (ce) begin
         mod_state_reg <= (state_next == ST_RUN);
      end
   end

   // Control interface usable once the boot delay has passed or the boot state is left
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control_ready_reg <= 1'b0;
      end else if (ce) begin
         if (state_reg == ST_BOOT) begin
            control_ready_reg <= (elapsed >= TMR_W'(CTRL_READY - 1));
         end else begin
            // Registers survive power-down, so access stays open
            control_ready_reg <= 1'b1;
         end
      end
   end

   // Remember a master volume command; set wins over a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vol_cmd_seen_reg <= 1'b0;
      end else if (ce) begin
         if (master_volume_write) begin
            vol_cmd_seen_reg <= 1'b1;
         end else if (state_reg == ST_PDN_HOLD) begin
            vol_cmd_seen_reg <= 1'b0;
         end
      end
   end

   // Audio flows only with valid modulation, rate and volume command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         audio_enable_reg <= 1'b0;
      end else if (ce) begin
         audio_enable_reg <= (state_next == ST_RUN) && rate_detected &&
            (vol_cmd_seen_reg || master_volume_write);
      end
   end

   // Step interval doubles with each slew setting
   assign slew_limit = TMR_W'(SLEW_BASE_CYCLES) << volume_slew_rate;
   assign slew_tick = (slew_count >= slew_limit - 1'b1);
   assign vol_target = mute_n ? master_volume : VOL_RESET;

   // Ramp one code per tick so mute never clicks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         volume_reg <= VOL_RESET;
      end else if (ce && slew_tick) begin
         if (volume_reg < vol_target) begin
            volume_reg <= volume_reg + 1'b1;
         end else if (volume_reg > vol_target) begin
            volume_reg <= volume_reg - 1'b1;
         end
      end
   end

   // Checks of the sequencing
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   pdn_drops_mod_a: assert property (
      (ce && !power_down_pin_n) |=> !mod_state_reg)
      else $error("modulation stayed high in power-down");
   boot_no_early_run_a: assert property (
      (state_reg == ST_BOOT) |-> !mod_state_reg)
      else $error("modulation valid before start-up done");
   ctrl_not_early_a: assert property (
      (state_reg == ST_BOOT && elapsed < TMR_W'(CTRL_READY - 1))
      |=> !control_ready_reg)
      else $error("control ready too early");
   // Judge only an update made while enabled; a frozen flag is old news
   audio_needs_cmd_a: assert property (
      ($past(ce) && audio_enable_reg) |-> mod_state_reg &&
      $past(rate_detected) &&
      ($past(vol_cmd_seen_reg) || $past(master_volume_write)))
      else $error("audio enabled without run, rate or volume command");
   fault_drops_mod_a: assert property (
      (ce && power_down_pin_n && state_reg == ST_RUN &&
       !backend_fault_input_n) |=> !mod_state_reg)
      else $error("fault did not invalidate output");
   recovery_holds_a: assert property (
      (state_reg == ST_ERR_REC) |-> !mod_state_reg)
      else $error("output valid during recovery");
   start_holds_low_a: assert property (
      (state_reg == ST_PDN_START || state_reg == ST_PDN_HOLD)
      |-> !mod_state_reg)
      else $error("output valid before power-up done");
   vol_step_one_a: assert property (
      ce |=> (volume_reg - $past(volume_reg) <= 8'h01) ||
             ($past(volume_reg) - volume_reg <= 8'h01))
      else $error("volume jumped by more than one step");
   mute_no_rise_a: assert property (
      (ce && !mute_n) |=> volume_reg <= $past(volume_reg))
      else $error("volume rose while muted");

   boot_to_run_c: cover property (
      state_reg == ST_BOOT ##1 state_reg == ST_RUN);
   err_recover_c: cover property (
      state_reg == ST_ERR_REC ##1 state_reg == ST_RUN);
   audio_on_c: cover property (!audio_enable_reg ##1 audio_enable_reg);
   mute_ramp_c: cover property (!mute_n && volume_reg != VOL_RESET);
endmodule : cps_sequencer
`default_nettype wire

// *** tb/cps_host_model.sv ***
// Host model driving the power-down and fault pins
`default_nettype none
module cps_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Requests from the bench
   input wire logic pdn_req,
   input wire logic fault_req,
   // Pins toward the sequencer
   output logic power_down_pin_n,
   output logic backend_fault_input_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] clk_cnt_reg; // Clocks seen while power-down held
   // Release power-down only after five clocks have run
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_cnt_reg <= 3'h0;
         power_down_pin_n <= 1'b1;
      end else if (pdn_req) begin
         clk_cnt_reg <= 3'h0;
         power_down_pin_n <= 1'b0;
      end else if (clk_cnt_reg < 3'h5) begin
         clk_cnt_reg <= clk_cnt_reg + 3'h1;
      end else begin
         power_down_pin_n <= 1'b1;
      end
   end
   // Fault pin follows the request one clock later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         backend_fault_input_n <= 1'b1;
      end else begin
         backend_fault_input_n <= !fault_req;
      end
   end
endmodule : cps_host_model
`default_nettype wire

// *** tb/cps_sequencer_bench.sv ***
// Self-checking bench for the control pin sequencer
`default_nettype none
module cps_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, pdn_req, fault_req, mute_n, rate_det, vol_wr;
   logic [7:0] mvol; // Target volume
   logic [1:0] slew; // Slew setting
   logic [3:0] rec_ms; // Recovery setting
   logic pdn_pin_n, fault_pin_n, mod_state, ctrl_rdy, audio_en;
   logic [7:0] volume;
   int fail_count = 0;
   int n_compared = 0;
   int n, m;
   // Watched levels, picked by index in waits
   wire logic [4:0] watch = {fault_pin_n, pdn_pin_n, audio_en, ctrl_rdy,
      mod_state};
   // Small timer values keep the run short
   cps_sequencer #(.CTRL_READY(20), .RUN_MIN(40), .PDN_START(30),
      .REC_UNIT(10)) dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .power_down_pin_n(pdn_pin_n), .backend_fault_input_n(fault_pin_n),
      .mute_n(mute_n), .rate_detected(rate_det),
      .master_volume_write(vol_wr), .master_volume(mvol),
      .volume_slew_rate(slew), .recovery_ms(rec_ms),
      .mod_state_reg(mod_state), .control_ready_reg(ctrl_rdy),
      .audio_enable_reg(audio_en), .volume_reg(volume));
   cps_host_model host_u (.clk(clk), .rst_n(rst_n), .pdn_req(pdn_req),
      .fault_req(fault_req), .power_down_pin_n(pdn_pin_n),
      .backend_fault_input_n(fault_pin_n));
   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic results;
      $display("Compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] in_rng(int v, int lo, int hi);
      return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
   endfunction : in_rng
   // Count edges until a watched level is high, bounded
   task automatic wait_hi(input int sel, input int lim, output int k);
      k = 0;
      while (watch[sel] !== 1'b1) begin
         @(posedge clk);
         #1;
         k++;
         if (k > lim) begin
            fail_count++;
            results();
         end
      end
   endtask : wait_hi
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : tick
   // Volume moves one code at a time, never in a jump
   task automatic ramp(input logic [7:0] tgt, input int lo, input int hi);
      logic [7:0] prev;
      int k;
      k = 0;
      prev = volume;
      while (volume !== tgt && k < hi + 100) begin
         tick(1);
         k++;
         if (volume !== prev && volume !== prev + 8'h01
             && volume !== prev - 8'h01) check(volume, prev);
         prev = volume;
      end
      check(volume, tgt);
      check(in_rng(k, lo, hi), 8'h01);
   endtask : ramp
   task automatic pulse_vol;
      @(posedge clk) vol_wr <= 1'b1;
      @(posedge clk) vol_wr <= 1'b0;
      wait_hi(2, 3, m);
      check({7'h0, audio_en}, 8'h01);
   endtask : pulse_vol
   task automatic boot_seq;
      check({5'h0, mod_state, ctrl_rdy, audio_en}, 8'h00);
      @(posedge clk) rst_n <= 1'b1;
      wait_hi(1, 30, n);
      check(in_rng(n, 19, 22), 8'h01);
      check({7'h0, mod_state}, 8'h00);
      wait_hi(0, 30, m);
      check(in_rng(n + m, 38, 42), 8'h01);
      tick(3);
      check({7'h0, audio_en}, 8'h00);
   endtask : boot_seq
   task automatic pdn_seq;
      @(posedge clk) pdn_req <= 1'b1;
      tick(2);
      check({7'h0, mod_state}, 8'h00);
      check({7'h0, ctrl_rdy}, 8'h01);
      @(posedge clk) pdn_req <= 1'b0;
      wait_hi(3, 12, n);
      wait_hi(0, 40, m);
      check(in_rng(m, 28, 32), 8'h01);
      tick(3);
      check({7'h0, audio_en}, 8'h00);
      // Volume command without a detected rate keeps audio off
      @(posedge clk) rate_det <= 1'b0;
      vol_wr <= 1'b1;
      @(posedge clk) vol_wr <= 1'b0;
      tick(2);
      check({7'h0, audio_en}, 8'h00);
      @(posedge clk) rate_det <= 1'b1;
      tick(2);
      check({7'h0, audio_en}, 8'h01);
      pulse_vol();
   endtask : pdn_seq
   task automatic fault_seq(input logic [3:0] r, input int ms);
      @(posedge clk) rec_ms <= r;
      fault_req <= 1'b1;
      tick(3);
      check({7'h0, mod_state}, 8'h00);
      @(posedge clk) fault_req <= 1'b0;
      wait_hi(4, 4, n);
      wait_hi(0, 120, m);
      check(in_rng(m, ms * 10 - 2, ms * 10 + 2), 8'h01);
   endtask : fault_seq
   initial begin
      {rst_n, pdn_req, fault_req, vol_wr} = 4'h0;
      {mute_n, rate_det} = 2'h3;
      mvol = 8'h00;
      slew = 2'h0;
      rec_ms = 4'h1;
      tick(16);
      boot_seq();
      @(posedge clk) mvol <= 8'h03;
      ramp(8'h03, 500, 800);
      @(posedge clk) mute_n <= 1'b0;
      ramp(8'h00, 500, 800);
      // Slower slew setting doubles the step interval
      @(posedge clk) mute_n <= 1'b1;
      slew <= 2'h1;
      ramp(8'h03, 1000, 1600);
      pulse_vol();
      pdn_seq();
      fault_seq(4'h0, 1);
      fault_seq(4'h1, 1);
      fault_seq(4'ha, 10);
      fault_seq(4'hf, 10);
      @(posedge clk) rst_n <= 1'b0;
      #1;
      check({5'h0, mod_state, ctrl_rdy, audio_en}, 8'h00);
      results();
   end
endmodule : cps_sequencer_bench
`default_nettype wire
